// ===== hdl/osc_cfg.svh
// Constants for the oscillator configuration word block
`ifndef OSC_CFG_SVH
`define OSC_CFG_SVH
`define OCW_WIDTH          14
`define OCW_FCM_BIT        13
`define OCW_SWITCH_BIT     11
`define OCW_CLOCK_OUTPUT_FUNCTION_BIT     8
`define OCW_RST_LSB        4
`define OCW_EXT_LSB        0
`define OCW_UNIMPL_MASK    14'h168c
`define OCW_BLANK_VALUE    14'h3fff
`define ADDR_CONFIG        4'h0
`define ADDR_CURRENT       4'h1
`define ADDR_NEW_SEL       4'h2
`define ADDR_STATUS        4'h3
`define CLOCK_OUTPUT_FUNCTION_DIV_HALF    1'h1
`endif

// ===== hdl/osc_pkg.sv
// Types for the oscillator configuration word block
package osc_pkg;
  typedef enum logic [2:0] {
    SRC_INT_FAST_32M = 3'h0,
    SRC_EXT_PLL      = 3'h1,
    SRC_RESV2        = 3'h2,
    SRC_SECONDARY    = 3'h3,
    SRC_INT_SLOW     = 3'h4,
    SRC_RESV5        = 3'h5,
    SRC_INT_FAST_1M  = 3'h6,
    SRC_EXT_DIRECT   = 3'h7
  } src_code_t;
  typedef enum logic [2:0] {
    EXT_LOW_POWER  = 3'h0,
    EXT_MID        = 3'h1,
    EXT_FAST       = 3'h2,
    EXT_UNIMPL     = 3'h3,
    EXT_OFF        = 3'h4,
    EXT_CLK_LOW    = 3'h5,
    EXT_CLK_MID    = 3'h6,
    EXT_CLK_HIGH   = 3'h7
  } ext_mode_t;
  typedef struct packed {
    logic       failsafe_monitor_enable;
    logic       clock_switch_permit;
    logic       clock_output_enable_n;
    src_code_t  reset_source_select;
    ext_mode_t  external_osc_mode;
  } cfg_fields_t;
  typedef struct packed {
    logic       ext_osc_enable;
    logic       ext_use_pll;
    logic       ext_is_clock_input;
    logic       clock_output_function_allowed;
    logic       src_valid;
  } decode_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [13:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
endpackage

// ===== hdl/osc_mode_decode.sv
// Combinational decode of the source code and external mode into controls
module osc_mode_decode (
  input  wire logic [2:0]      src_i,
  input  wire logic [2:0]      ext_i,
  output osc_pkg::decode_t     dec_o
);
  always_comb begin
    dec_o = '0;
    // Oscillator is off for mode 100 and the unimplemented code
    dec_o.ext_osc_enable     = (ext_i != osc_pkg::EXT_OFF) && (ext_i != osc_pkg::EXT_UNIMPL);
    dec_o.ext_is_clock_input = (ext_i == osc_pkg::EXT_CLK_HIGH) || (ext_i == osc_pkg::EXT_CLK_MID) ||
                               (ext_i == osc_pkg::EXT_CLK_LOW);
    // Clock-out is only honoured when the pin is not taken by a crystal or clock input
    dec_o.clock_output_function_allowed     = !(dec_o.ext_is_clock_input || ext_i == osc_pkg::EXT_FAST ||
                                 ext_i == osc_pkg::EXT_MID || ext_i == osc_pkg::EXT_LOW_POWER);
    dec_o.ext_use_pll        = (src_i == osc_pkg::SRC_EXT_PLL);
    dec_o.src_valid          = (src_i != osc_pkg::SRC_RESV5) && (src_i != osc_pkg::SRC_RESV2);
  end
endmodule

// ===== hdl/osc_config_word.sv
// Oscillator configuration word: latch at reset, clock-out, switch gating
// What this block does
// - Monitor enable field set turns the fail-safe monitor timer on, clear keeps it off.
// - Switch enable field gates software writes to new source and divider selections.
// - Word positions 12, 10-9, 7, 3 and 2 (the unimplemented mask) read back as one.
// - Clock-out field ignored in external clock or any crystal mode.
// - Otherwise clock-out field zero drives system clock over four on the pin.
// - Current source selection loads from the reset source field at reset.
// - Source code 111 is external oscillator per its mode; 101 is reserved.
// - Mode 111 is external clock above 8 MHz; 100 leaves oscillator off.
// - Source codes 110, 100, 011, 001, 000 select the listed internal or external sources.
// - Mode 110 is external clock 100 kHz to 8 MHz; 101 below 100 kHz.
//
// The register offsets and the strobed register port are this design's own decisions.
`include "osc_cfg.svh"

module osc_config_word (
  input  wire logic                    mclk_i,
  input  wire logic                    arst_n_i,
  input  wire logic [`OCW_WIDTH-1:0]   cfg_word_i,
  input  wire logic [3:0]              reg_addr_i,
  input  wire logic [13:0]             reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic      [13:0]             reg_rdata_o,
  output logic                         failsafe_clock_monitor_en_o,
  output logic      [2:0]              current_source_select_o,
  output logic      [2:0]              new_source_select_o,
  output logic      [3:0]              new_divider_select_o,
  output logic                         external_oscillator_en_o,
  output logic                         external_pll_en_o,
  output logic      [2:0]              external_osc_mode_o,
  output logic                         clock_output_function_o,
  output logic                         clock_output_oe_o,
  output logic                         cfg_loaded_o
);

  typedef struct packed {
    logic [1:0]              sync;
    logic [`OCW_WIDTH-1:0]   word_s1;
    logic [`OCW_WIDTH-1:0]   word_s2;
    logic                    loaded;
    logic [`OCW_WIDTH-1:0]   word;
    osc_pkg::cfg_fields_t    fields;
    logic [2:0]              cur_src;
    logic [2:0]              new_src;
    logic [3:0]              new_div;
    logic                    fcm_en;
    logic                    ext_en;
    logic                    pll_en;
    logic [2:0]              ext_mode;
    logic                    clk_div2;
    logic                    clk_out;
    logic                    clk_oe;
    logic                    div_en;
    logic [13:0]             rdata;
  } state_t;

  state_t state_q;
  state_t state_d;
  osc_pkg::decode_t dec;
  osc_pkg::reg_req_t req;

  // Bundle the register port for the decode below
  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  osc_mode_decode u_decode (
    .src_i (state_q.fields.reset_source_select),
    .ext_i (state_q.fields.external_osc_mode),
    .dec_o (dec)
  );

  // Next-state logic for the whole block
  always_comb begin
    state_d = state_q;
    // Settle count: capture waits two edges after reset is released
    state_d.sync = {state_q.sync[0], 1'b1};
    // Word pins come from outside the clock domain, so two flops before any use
    state_d.word_s1 = cfg_word_i;
    state_d.word_s2 = state_q.word_s1;
    // Capture exactly once, on the first cycle after reset has settled
    if (state_q.sync[1] && !state_q.loaded) begin
      state_d.loaded = 1'b1;
      state_d.word   = state_q.word_s2 | `OCW_UNIMPL_MASK;
      state_d.fields.failsafe_monitor_enable = state_q.word_s2[`OCW_FCM_BIT];
      state_d.fields.clock_switch_permit     = state_q.word_s2[`OCW_SWITCH_BIT];
      state_d.fields.clock_output_enable_n   = state_q.word_s2[`OCW_CLOCK_OUTPUT_FUNCTION_BIT];
      state_d.fields.reset_source_select     = osc_pkg::src_code_t'(state_q.word_s2[`OCW_RST_LSB +: 3]);
      state_d.fields.external_osc_mode       = osc_pkg::ext_mode_t'(state_q.word_s2[`OCW_EXT_LSB +: 3]);
      // Source code for the first clock software runs from
      state_d.cur_src = state_q.word_s2[`OCW_RST_LSB +: 3];
      state_d.new_src = state_q.word_s2[`OCW_RST_LSB +: 3];
    end
    // Derived controls follow the held fields
    if (state_q.loaded) begin
      state_d.fcm_en   = state_q.fields.failsafe_monitor_enable;
      state_d.ext_mode = state_q.fields.external_osc_mode;
      // Source 111 or 001 run the external oscillator; reserved codes start nothing
      state_d.ext_en   = dec.ext_osc_enable && dec.src_valid &&
                         (state_q.cur_src == osc_pkg::SRC_EXT_DIRECT || dec.ext_use_pll);
      state_d.pll_en   = dec.ext_use_pll && dec.ext_osc_enable;
    end
    // System clock over four: toggle every second cycle
    state_d.div_en = ~state_q.div_en;
    if (state_q.div_en) begin
      state_d.clk_div2 = ~state_q.clk_div2;
    end
    // Clock-out only when allowed by the mode and the active-low field is zero
    state_d.clk_oe  = state_q.loaded && dec.clock_output_function_allowed &&
                      !state_q.fields.clock_output_enable_n;
    state_d.clk_out = state_d.clk_oe && state_d.clk_div2;
    // Software writes to the new selections only when switching is permitted
    if (req.wr && req.addr == `ADDR_NEW_SEL && state_q.loaded &&
        state_q.fields.clock_switch_permit) begin
      state_d.new_src = req.wdata[6:4];
      state_d.new_div = req.wdata[3:0];
    end
    // Read data stand in the cycle after the strobe only
    state_d.rdata = '0;
    if (req.rd) begin
      unique case (req.addr)
        `ADDR_CONFIG:  state_d.rdata = state_q.loaded ? state_q.word : `OCW_BLANK_VALUE;
        `ADDR_CURRENT: state_d.rdata = {11'h000, state_q.cur_src};
        `ADDR_NEW_SEL: state_d.rdata = {7'h00, state_q.new_src, state_q.new_div};
        `ADDR_STATUS:  state_d.rdata = {8'h00, dec.src_valid, state_q.pll_en, state_q.ext_en,
                                        state_q.clk_oe, state_q.fcm_en, state_q.loaded};
        default:       state_d.rdata = '0;
      endcase
    end
  end

  // Single state register
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata_o                 = state_q.rdata;
  assign failsafe_clock_monitor_en_o = state_q.fcm_en;
  assign current_source_select_o     = state_q.cur_src;
  assign new_source_select_o         = state_q.new_src;
  assign new_divider_select_o        = state_q.new_div;
  assign external_oscillator_en_o    = state_q.ext_en;
  assign external_pll_en_o           = state_q.pll_en;
  assign external_osc_mode_o         = state_q.ext_mode;
  assign clock_output_function_o     = state_q.clk_out;
  assign clock_output_oe_o           = state_q.clk_oe;
  assign cfg_loaded_o                = state_q.loaded;
endmodule

// ===== sim/osc_config_word_properties.sv
// Checker for the oscillator configuration word block
module osc_config_word_properties (
  input wire logic        mclk_i,
  input wire logic        arst_n_i,
  input wire logic [13:0] cfg_word_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [13:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [13:0] reg_rdata_o,
  input wire logic        failsafe_clock_monitor_en_o,
  input wire logic [2:0]  current_source_select_o,
  input wire logic [2:0]  new_source_select_o,
  input wire logic [3:0]  new_divider_select_o,
  input wire logic        external_oscillator_en_o,
  input wire logic        external_pll_en_o,
  input wire logic [2:0]  external_osc_mode_o,
  input wire logic        clock_output_function_o,
  input wire logic        clock_output_oe_o,
  input wire logic        cfg_loaded_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] held_q;
  logic [13:0] wd_q;
  logic        live_q;
  wire logic   st_w = cfg_loaded_o & live_q;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // Private copy of the word, frozen once the block reports it loaded
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      held_q <= 14'h0000;
      live_q <= 1'b0;
    end else begin
      if (!cfg_loaded_o) held_q <= cfg_word_i;
      live_q <= cfg_loaded_o;
    end
  end
  // Last write data, so the write check needs no $past on a slice
  always_ff @(posedge mclk_i) wd_q <= reg_wdata_i;
  AST_FCM: assert property (st_w |-> failsafe_clock_monitor_en_o == held_q[13])
    else $error("monitor enable wrong");
  AST_GATE: assert property (reg_wr_i && !held_q[11] |=> $stable({new_source_select_o, new_divider_select_o}))
    else $error("switch write not blocked");
  AST_TAKE: assert property (cfg_loaded_o && reg_wr_i && reg_addr_i == 4'h2 && held_q[11] |=>
    {new_source_select_o, new_divider_select_o} == wd_q[6:0])
    else $error("switch write lost");
  AST_UNIMPL: assert property (reg_rd_i && reg_addr_i == 4'h0 |=> (reg_rdata_o & 14'h168c) == 14'h168c)
    else $error("unimplemented bits not one");
  AST_OE: assert property (st_w |-> clock_output_oe_o == (!held_q[8] && held_q[2:0] inside {3'h3, 3'h4}))
    else $error("clock out enable wrong");
  AST_DIV4: assert property ($rose(clock_output_function_o) |=>
    clock_output_function_o ##1 !clock_output_function_o [*2] ##1 clock_output_function_o)
    else $error("clock out not divide by four");
  AST_SRC: assert property (st_w |-> current_source_select_o == held_q[6:4])
    else $error("current source wrong");
  AST_EXT: assert property (st_w |-> external_oscillator_en_o == (held_q[6:4] inside {3'h7, 3'h1} &&
    !(held_q[2:0] inside {3'h3, 3'h4})) && external_pll_en_o == (held_q[6:4] == 3'h1 && external_oscillator_en_o))
    else $error("external oscillator enable wrong");
  AST_MODE: assert property (st_w |-> external_osc_mode_o == held_q[2:0])
    else $error("external mode wrong");
endmodule
bind osc_config_word osc_config_word_properties chk (
  .mclk_i                      (mclk_i),
  .arst_n_i                    (arst_n_i),
  .cfg_word_i                  (cfg_word_i),
  .reg_addr_i                  (reg_addr_i),
  .reg_wdata_i                 (reg_wdata_i),
  .reg_wr_i                    (reg_wr_i),
  .reg_rd_i                    (reg_rd_i),
  .reg_rdata_o                 (reg_rdata_o),
  .failsafe_clock_monitor_en_o (failsafe_clock_monitor_en_o),
  .current_source_select_o     (current_source_select_o),
  .new_source_select_o         (new_source_select_o),
  .new_divider_select_o        (new_divider_select_o),
  .external_oscillator_en_o    (external_oscillator_en_o),
  .external_pll_en_o           (external_pll_en_o),
  .external_osc_mode_o         (external_osc_mode_o),
  .clock_output_function_o     (clock_output_function_o),
  .clock_output_oe_o           (clock_output_oe_o),
  .cfg_loaded_o                (cfg_loaded_o)
);

// ===== sim/osc_pin_model.sv
// Second oscillator pin with pull-up, counting rising edges
module osc_pin_model (
  input  wire logic mclk_i,
  input  wire logic oe_i,
  input  wire logic fn_i,
  output int        rises_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q = 1'b1;
  // Undriven pin floats to its pull-up, never shows stale data
  wire logic pin_w = oe_i ? fn_i : 1'b1;
  initial rises_o = 0;
  always @(posedge mclk_i) begin
    if (pin_w && !last_q) rises_o <= rises_o + 1;
    last_q <= pin_w;
  end
endmodule

// ===== sim/tb.sv
// Self-checking bench for the oscillator configuration word block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [13:0] cw = 14'h0000;
  logic [3:0]  ad = 4'h0;
  logic [13:0] wd = 14'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [13:0] rdat;
  logic        fcm, ext, pll, oe, fn, ld;
  logic [2:0]  cur, nsrc, mode;
  logic [3:0]  new_divider_select;
  int          rises;
  int          fails = 0;
  int          checked = 0;
  always #20 mclk_i = ~mclk_i;
  osc_config_word uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cfg_word_i(cw), .reg_addr_i(ad), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .failsafe_clock_monitor_en_o(fcm), .current_source_select_o(cur),
    .new_source_select_o(nsrc), .new_divider_select_o(new_divider_select), .external_oscillator_en_o(ext), .external_pll_en_o(pll),
    .external_osc_mode_o(mode), .clock_output_function_o(fn), .clock_output_oe_o(oe), .cfg_loaded_o(ld));
  osc_pin_model pin (.mclk_i(mclk_i), .oe_i(oe), .fn_i(fn), .rises_o(rises));
  task automatic cmp(input string nm, input logic [13:0] e, input logic [13:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Reset with a new word; the load wait is bounded
  task automatic boot(input logic [13:0] w);
    @(posedge mclk_i);
    arst_n_i <= 1'b0;
    cw <= w;
    repeat (6) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    for (int n = 0; n < 20 && ld !== 1'b1; n++) @(negedge mclk_i);
    if (ld !== 1'b1) begin
      fails++;
      conclude();
    end
    repeat (2) @(negedge mclk_i);
  endtask
  task automatic rd_cmp(input logic [3:0] a, input logic [13:0] e, input string nm);
    @(posedge mclk_i);
    ad <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    @(negedge mclk_i);
    cmp(nm, e, rdat);
  endtask
  // One word per pass: source and mode both take code i for 0-7, case 8 tests a masked clock-out in source 000 and mode 100
  task automatic check_word(input int i);
    logic [2:0]  m;
    logic [13:0] w;
    logic        e_ext;
    logic        e_pll;
    logic        e_oe;
    int          r0;
    m = (i == 8) ? 3'h4 : i[2:0];
    w = {i[0], 1'b0, i[1], 2'b00, i == 8, 1'b0, i[2:0], 1'b0, m};
    e_ext = w[6:4] inside {3'h7, 3'h1} && !(m inside {3'h3, 3'h4});
    e_pll = w[6:4] == 3'h1 && e_ext;
    e_oe  = !w[8] && m inside {3'h3, 3'h4};
    boot(w);
    cmp("monitor", 14'(w[13]), 14'(fcm));
    cmp("current", 14'(w[6:4]), 14'(cur));
    cmp("ext_en", 14'(e_ext), 14'(ext));
    cmp("pll", 14'(e_pll), 14'(pll));
    cmp("mode", 14'(m), 14'(mode));
    cmp("clk_oe", 14'(e_oe), 14'(oe));
    rd_cmp(4'h0, w | 14'h168c, "word");
    rd_cmp(4'h1, 14'(w[6:4]), "cur_reg");
    rd_cmp(4'h3, {8'h00, !(w[6:4] inside {3'h5, 3'h2}), e_pll, e_ext, e_oe, w[13], 1'b1}, "status");
    @(posedge mclk_i);
    ad <= 4'h2;
    wd <= 14'h005a;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
    @(negedge mclk_i);
    cmp("new_src", w[11] ? 14'h5 : 14'(w[6:4]), 14'(nsrc));
    cmp("new_div", w[11] ? 14'ha : 14'h0, 14'(new_divider_select));
    r0 = rises;
    repeat (16) @(negedge mclk_i);
    cmp("pin_rises", e_oe ? 14'h4 : 14'h0, 14'(rises - r0));
    @(posedge mclk_i);
    cw <= ~w;
    repeat (4) @(negedge mclk_i);
    cmp("held", 14'(w[6:4]), 14'(cur));
  endtask
  initial begin
    for (int i = 0; i <= 8; i++) check_word(i);
    rd_cmp(4'hf, 14'h0000, "unmapped");
    conclude();
  end
endmodule
